// >>> logic/psa_port.sv
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module psa_port (
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic PCM_CLK_IN,
   output logic PCM_CLK_OUT,
   output logic PCM_CLK_OE_OUT,
   input wire logic PCM_SYNC_IN,
   output logic PCM_SYNC_OUT,
   output logic PCM_SYNC_OE_OUT,
   input wire logic PCM_DIN_IN,
   output logic PCM_DOUT_OUT,
   output logic PCM_DOUT_OE_OUT
);
   typedef psa_pkg::psa_fill_e psa_fill_e;

   // byte-lane merge for register writes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   // build the 16-bit slot word from a sample and the spare-bit fill
   function automatic logic [15:0] build_word(input logic [12:0] s, input logic [1:0] lowsp,
                                              input logic [1:0] mode, input logic [2:0] fval);
      logic [15:0] body;
      logic [15:0] mask;
      logic [15:0] fill;
      body = {3'h0, s} << lowsp;
      mask = 16'h1FFF << lowsp;
      unique case (psa_fill_e'(mode))
         psa_pkg::FILL_ZERO: fill = 16'h0000;
         psa_pkg::FILL_ONE: fill = 16'hFFFF;
         psa_pkg::FILL_SIGN: fill = {16{s[12]}};
         psa_pkg::FILL_PROG: fill = {fval, 10'h000, fval};
      endcase
      return (body & mask) | (fill & ~mask);
   endfunction

   logic [6:0] ctrl_r;
   logic [14:0] slot_r;
   logic [7:0] fmt_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [8:0] div_r;
   logic bclk_r;
   logic clk_lvl_prev_r;
   logic sync_prev_r;
   logic start_pend_r;
   logic [7:0] cnt_r;
   logic dout_r;
   logic dout_oe_r;
   logic sync_r;
   logic clk_oe_r;
   logic [15:0] rx_sh_r;
   logic [12:0] hold_r [psa_pkg::NUM_CH];
   logic [2:0] hold_full_r;
   logic [12:0] rxd_r [psa_pkg::NUM_CH];
   logic [2:0] rxv_r;
   logic [2:0] pin_q;

   psa_stream_if #(.W(psa_pkg::FIFO_W)) tx_wr_if ();
   psa_stream_if #(.W(psa_pkg::FIFO_W)) tx_rd_if ();

   // synchronised link pins: clock, sync, data
   psa_sync #(.W(3)) u_sync (
      .clk_in(SYS_CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in({PCM_DIN_IN, PCM_SYNC_IN, PCM_CLK_IN}),
      .q_out(pin_q)
   );

   // four-word transmit sample queue between the bus and the slot holders
   psa_fifo #(.W(psa_pkg::FIFO_W), .D(psa_pkg::FIFO_DEPTH)) u_fifo (
      .clk_in(SYS_CLK_IN),
      .rstn_in(RSTN_IN),
      .wr(tx_wr_if),
      .rd(tx_rd_if)
   );

   // control fields
   wire en = ctrl_r[psa_pkg::CTRL_EN];
   wire master = ctrl_r[psa_pkg::CTRL_MASTER];
   wire long_sync = ctrl_r[psa_pkg::CTRL_LONG];
   wire fs16 = ctrl_r[psa_pkg::CTRL_FS16];
   wire [2:0] rate_raw = ctrl_r[psa_pkg::CTRL_RATE_LSB +: 3];
   wire [2:0] rate = (rate_raw > psa_pkg::RATE_MAX) ? psa_pkg::RATE_MAX : rate_raw;
   wire [1:0] fill_mode = fmt_r[psa_pkg::FMT_FILL_LSB +: 2];
   wire [2:0] fill_val = fmt_r[psa_pkg::FMT_FVAL_LSB +: 3];
   wire [1:0] lowsp = fmt_r[psa_pkg::FMT_LOWSP_LSB +: 2];
   wire lsbf = fmt_r[psa_pkg::FMT_LSBF];

   // frame length in bits: 16 per slot, slots scale with bit rate
   wire [8:0] fb_8k = psa_pkg::MIN_FRAME_BITS << rate;
   wire [8:0] fb_sel = (fs16 && rate != 3'h0) ? (fb_8k >> 1) : fb_8k;
   wire [7:0] last = 8'(fb_sel - 9'h001);

   // bus decode
   wire req = WB_CYC_IN & WB_STB_IN & ~ack_r;
   wire sel_ctrl = (WB_ADR_IN == psa_pkg::OFS_CTRL);
   wire sel_slot = (WB_ADR_IN == psa_pkg::OFS_SLOT);
   wire sel_fmt = (WB_ADR_IN == psa_pkg::OFS_FMT);
   wire sel_txd = (WB_ADR_IN == psa_pkg::OFS_TXDATA);
   wire sel_stat = (WB_ADR_IN == psa_pkg::OFS_STATUS);
   wire [2:0] sel_rx = {WB_ADR_IN == psa_pkg::OFS_RX2, WB_ADR_IN == psa_pkg::OFS_RX1,
                        WB_ADR_IN == psa_pkg::OFS_RX0};
   wire tx_push = req & WB_WE_IN & sel_txd;
   wire go = req & ~(tx_push & ~tx_wr_if.ready); // full queue stalls the bus
   wire wr = go & WB_WE_IN;
   wire [2:0] rx_rd = {3{go & ~WB_WE_IN}} & sel_rx;
   wire [31:0] wdat_ctrl = wmerge({25'h0, ctrl_r}, WB_DAT_IN, WB_SEL_IN);
   wire [31:0] wdat_slot = wmerge({17'h0, slot_r}, WB_DAT_IN, WB_SEL_IN);
   wire [31:0] wdat_fmt = wmerge({24'h0, fmt_r}, WB_DAT_IN, WB_SEL_IN);
   wire [31:0] status = {24'h0, ~tx_rd_if.valid, ~tx_wr_if.ready, hold_full_r, rxv_r};
   wire [31:0] rd_mux = sel_ctrl ? {25'h0, ctrl_r} :
                        sel_slot ? {17'h0, slot_r} :
                        sel_fmt ? {24'h0, fmt_r} :
                        sel_stat ? status :
                        sel_rx[0] ? {19'h0, rxd_r[0]} :
                        sel_rx[1] ? {19'h0, rxd_r[1]} :
                        sel_rx[2] ? {19'h0, rxd_r[2]} : 32'h0000_0000;

   assign tx_wr_if.valid = tx_push;
   assign tx_wr_if.data = {WB_DAT_IN[psa_pkg::TXD_CH_LSB +: 2], WB_DAT_IN[12:0]};

   // master bit clock divider
   wire [8:0] half = 9'(psa_pkg::HALF_CYC[rate]);
   wire tick = en & master & (div_r == half - 9'h001);
   wire rise_m = tick & ~bclk_r;
   wire fall_m = tick & bclk_r;

   // slave edges from the filtered clock level
   wire clk_lvl = pin_q[0];
   wire sync_lvl = pin_q[1];
   wire din = pin_q[2];
   wire rise_s = en & ~master & clk_lvl & ~clk_lvl_prev_r;
   wire fall_s = en & ~master & ~clk_lvl & clk_lvl_prev_r;
   wire rise = rise_m | rise_s;
   wire fall = fall_m | fall_s;

   // frame alignment: long sync starts in the bit now running
   wire resync = fall_s & long_sync & sync_lvl & ~sync_prev_r;
   wire short_seen = fall_s & ~long_sync & sync_lvl;
   wire [7:0] cnt_nxt = (start_pend_r || cnt_r == last) ? 8'h00 : cnt_r + 8'h01;
   wire [7:0] pos = resync ? 8'h00 : cnt_nxt;
   wire drive = rise | resync;

   // slot ownership for the bit about to start and the bit in progress
   logic [2:0] hit_pos;
   logic [2:0] hit_cur;
   for (genvar c = 0; c < psa_pkg::NUM_CH; c++) begin : g_hit
      wire [4:0] fld = slot_r[c*psa_pkg::SLOT_FLD_W +: psa_pkg::SLOT_FLD_W];
      assign hit_pos[c] = fld[psa_pkg::SLOT_EN_POS] & (fld[3:0] == pos[7:4]);
      assign hit_cur[c] = fld[psa_pkg::SLOT_EN_POS] & (fld[3:0] == cnt_r[7:4]);
   end
   wire [1:0] ch_pos = hit_pos[0] ? 2'h0 : hit_pos[1] ? 2'h1 : hit_pos[2] ? 2'h2 : psa_pkg::CH_NONE;
   wire [1:0] ch_cur = hit_cur[0] ? 2'h0 : hit_cur[1] ? 2'h1 : hit_cur[2] ? 2'h2 : psa_pkg::CH_NONE;
   wire own_pos = (ch_pos != psa_pkg::CH_NONE);
   wire own_cur = (ch_cur != psa_pkg::CH_NONE);
   wire last_bit = (cnt_r[3:0] == 4'hF);

   // transmit word and bit selection
   wire [12:0] tx_sample = (own_pos && hold_full_r[ch_pos]) ? hold_r[ch_pos] : 13'h0000;
   wire [15:0] tx_word = build_word(tx_sample, lowsp, fill_mode, fill_val);
   wire [3:0] tx_idx = lsbf ? pos[3:0] : 4'hF - pos[3:0];
   wire tx_bit = tx_word[tx_idx];

   // receive shift in the chosen bit order; spare bits drop out here
   wire [15:0] rx_word = lsbf ? {din, rx_sh_r[15:1]} : {rx_sh_r[14:0], din};
   wire [15:0] rx_shifted = rx_word >> lowsp;
   wire [12:0] rx_sample = rx_shifted[12:0];
   wire rx_done = fall & own_cur & last_bit;

   // queue head goes to its channel holder once that holder is free
   wire [1:0] head_ch = tx_rd_if.data[14:13];
   wire head_bad = (head_ch == psa_pkg::CH_NONE);
   assign tx_rd_if.ready = head_bad | ~hold_full_r[head_ch];
   wire pop = tx_rd_if.valid & tx_rd_if.ready & ~head_bad;

   // master sync level for the bit about to start
   wire sync_nxt = long_sync ? (pos < 8'(psa_pkg::LONG_SYNC_BITS)) : (pos == last);

   assign WB_ACK_OUT = ack_r;
   assign WB_DAT_OUT = dat_r;
   assign PCM_CLK_OUT = bclk_r;
   assign PCM_CLK_OE_OUT = clk_oe_r;
   assign PCM_SYNC_OUT = sync_r;
   assign PCM_SYNC_OE_OUT = clk_oe_r;
   assign PCM_DOUT_OUT = dout_r;
   assign PCM_DOUT_OE_OUT = dout_oe_r;

   // bus slave: one-cycle registered ack, read data latched with it
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= go;
         if (go && !WB_WE_IN) begin
            dat_r <= rd_mux;
         end
      end
   end

   // configuration registers
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ctrl_r <= psa_pkg::CTRL_RST;
         slot_r <= psa_pkg::SLOT_RST;
         fmt_r <= psa_pkg::FMT_RST;
      end else begin
         if (wr && sel_ctrl) begin
            ctrl_r <= wdat_ctrl[6:0];
         end
         if (wr && sel_slot) begin
            slot_r <= wdat_slot[14:0];
         end
         if (wr && sel_fmt) begin
            fmt_r <= wdat_fmt[7:0];
         end
      end
   end

   // master bit clock generation
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         div_r <= 9'h000;
         bclk_r <= 1'b0;
         clk_oe_r <= 1'b0;
      end else begin
         clk_oe_r <= en & master;
         if (!(en && master)) begin
            div_r <= 9'h000;
            bclk_r <= 1'b0;
         end else if (tick) begin
            div_r <= 9'h000;
            bclk_r <= ~bclk_r;
         end else begin
            div_r <= div_r + 9'h001;
         end
      end
   end

   // slot counter and frame alignment
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         clk_lvl_prev_r <= 1'b0;
         sync_prev_r <= 1'b0;
         start_pend_r <= 1'b0;
         cnt_r <= 8'h00;
      end else begin
         clk_lvl_prev_r <= clk_lvl;
         if (!en) begin
            start_pend_r <= 1'b1; // first rise after enable opens bit zero
            cnt_r <= 8'h00;
         end else if (drive) begin
            cnt_r <= pos;
            start_pend_r <= 1'b0;
         end else if (short_seen) begin
            start_pend_r <= 1'b1;
         end
         if (fall_s) begin
            sync_prev_r <= sync_lvl;
         end
      end
   end

   // serial output, its enable and the master frame sync
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         dout_r <= 1'b0;
         dout_oe_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         if (!en) begin
            dout_oe_r <= 1'b0;
            sync_r <= 1'b0;
         end else if (drive) begin
            dout_r <= tx_bit;
            dout_oe_r <= own_pos;
         end else if (fall && own_cur && last_bit) begin
            dout_oe_r <= 1'b0;
         end
         if (rise_m) begin
            sync_r <= sync_nxt;
         end
      end
   end

   // receive shift register
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rx_sh_r <= 16'h0000;
      end else if (fall && own_cur) begin
         rx_sh_r <= rx_word;
      end
   end

   // per-channel transmit holders and receive samples
   for (genvar c = 0; c < psa_pkg::NUM_CH; c++) begin : g_ch
      always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
         if (!RSTN_IN) begin
            hold_r[c] <= 13'h0000;
            hold_full_r[c] <= 1'b0;
            rxd_r[c] <= 13'h0000;
            rxv_r[c] <= 1'b0;
         end else begin
            if (pop && head_ch == 2'(c)) begin
               hold_r[c] <= tx_rd_if.data[12:0];
               hold_full_r[c] <= 1'b1;
            end else if (rx_done && ch_cur == 2'(c)) begin
               hold_full_r[c] <= 1'b0; // sample used in this slot
            end
            if (rx_done && ch_cur == 2'(c)) begin
               rxd_r[c] <= rx_sample;
               rxv_r[c] <= 1'b1; // new sample wins over a read in the same cycle
            end else if (rx_rd[c]) begin
               rxv_r[c] <= 1'b0;
            end
         end
      end
   end
endmodule // psa_port

// >>> logic/psa_pkg.sv
package psa_pkg;
   // system clock and link rates
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int NUM_RATES = 5;
   localparam int BIT_RATE_HZ [NUM_RATES] = '{128_000, 256_000, 512_000, 1_024_000, 2_048_000};
   // half bit period in system cycles, rounded down
   localparam int HALF_CYC [NUM_RATES] = '{SYS_CLK_HZ / (2 * BIT_RATE_HZ[0]),
      SYS_CLK_HZ / (2 * BIT_RATE_HZ[1]), SYS_CLK_HZ / (2 * BIT_RATE_HZ[2]),
      SYS_CLK_HZ / (2 * BIT_RATE_HZ[3]), SYS_CLK_HZ / (2 * BIT_RATE_HZ[4])};
   localparam logic [2:0] RATE_MAX = 3'h4;

   // channel and word geometry
   localparam int NUM_CH = 3;
   localparam int SLOT_BITS = 16;
   localparam int SAMPLE_BITS = 13;
   localparam int LONG_SYNC_BITS = 3;
   localparam logic [8:0] MIN_FRAME_BITS = 9'h010;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_W = 15;
   localparam logic [1:0] CH_NONE = 2'h3;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SLOT = 8'h04;
   localparam logic [7:0] OFS_FMT = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_RX0 = 8'h14;
   localparam logic [7:0] OFS_RX1 = 8'h18;
   localparam logic [7:0] OFS_RX2 = 8'h1C;

   // control register fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_MASTER = 1;
   localparam int CTRL_LONG = 2;
   localparam int CTRL_FS16 = 3;
   localparam int CTRL_RATE_LSB = 4;
   localparam logic [6:0] CTRL_RST = 7'h00;

   // slot register: per channel 4-bit slot number and an enable above it
   localparam int SLOT_FLD_W = 5;
   localparam int SLOT_EN_POS = 4;
   localparam logic [14:0] SLOT_RST = 15'h0000;

   // format register fields
   localparam int FMT_FILL_LSB = 0;
   localparam int FMT_FVAL_LSB = 2;
   localparam int FMT_LOWSP_LSB = 5;
   localparam int FMT_LSBF = 7;
   localparam logic [7:0] FMT_RST = 8'h60;

   // tx data register fields
   localparam int TXD_CH_LSB = 16;

   // status register fields
   localparam int STAT_RXV_LSB = 0;
   localparam int STAT_HOLD_LSB = 3;
   localparam int STAT_FULL = 6;
   localparam int STAT_EMPTY = 7;

   typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_PROG} psa_fill_e;
endpackage

// >>> logic/psa_stream_if.sv
`timescale 1ns/1ps
interface psa_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> logic/psa_sync.sv
`timescale 1ns/1ps
module psa_sync #(parameter int W = 1) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   wire [W-1:0] agree = ~(s2_r ^ s3_r);
   wire [W-1:0] q_nxt = (agree & s2_r) | (~agree & q_r);

   assign q_out = q_r;

   // three-stage chain; level moves once stages two and three agree
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end
endmodule // psa_sync

// >>> logic/psa_fifo.sv
`timescale 1ns/1ps
module psa_fifo #(parameter int W = 8, parameter int D = 4) (
   input wire logic clk_in,
   input wire logic rstn_in,
   psa_stream_if.snk wr,
   psa_stream_if.src rd
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   wire push = wr.valid & wr.ready;
   wire pop = rd.valid & rd.ready;
   wire [AW-1:0] wp_inc = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
   wire [AW-1:0] rp_inc = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;

   // honest full and empty from the fill count
   assign wr.ready = (cnt_r != (AW + 1)'(D));
   assign rd.valid = (cnt_r != '0);
   assign rd.data = mem_r[rp_r];

   // storage, pointers and fill count
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         for (int i = 0; i < D; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         if (push) begin
            mem_r[wp_r] <= wr.data;
            wp_r <= wp_inc;
         end
         if (pop) begin
            rp_r <= rp_inc;
         end
         cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule // psa_fifo

// >>> tb/psa_port_checker.sv
`timescale 1ns/1ps
// watches bus answers and master-side pcm pin timing
module psa_port_checker (
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic WB_ACK_OUT,
   input wire logic PCM_CLK_OUT,
   input wire logic PCM_CLK_OE_OUT,
   input wire logic PCM_SYNC_OUT,
   input wire logic PCM_SYNC_OE_OUT,
   input wire logic PCM_DOUT_OUT,
   input wire logic PCM_DOUT_OE_OUT
);
   logic clk_q_r;
   logic sync_q_r;
   logic [1:0] rise_cnt_r;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // counts bit clock rises since sync last rose
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         clk_q_r <= 1'b0;
         sync_q_r <= 1'b0;
         rise_cnt_r <= 2'h0;
      end else begin
         clk_q_r <= PCM_CLK_OUT;
         sync_q_r <= PCM_SYNC_OUT;
         if (PCM_SYNC_OUT && !sync_q_r) rise_cnt_r <= 2'h0;
         else if (PCM_CLK_OUT && !clk_q_r) rise_cnt_r <= rise_cnt_r + 2'h1;
      end
   end
   a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack stood longer than one cycle");
   a_oe_pair: assert property (PCM_CLK_OE_OUT == PCM_SYNC_OE_OUT)
      else $error("clock and sync enables differ");
   a_clk_idle: assert property (!PCM_CLK_OE_OUT |-> !PCM_CLK_OUT)
      else $error("bit clock moves while not driven");
   a_half_min: assert property ($rose(PCM_CLK_OUT) |=> (PCM_CLK_OUT || !PCM_CLK_OE_OUT)[*8])
      else $error("bit clock high phase too short");
   a_sync_edge: assert property ($rose(PCM_SYNC_OUT) |-> $rose(PCM_CLK_OUT))
      else $error("sync not launched on a clock rise");
   a_sync_width: assert property ($fell(PCM_SYNC_OUT) && PCM_SYNC_OE_OUT |=>
      rise_cnt_r == 2'h1 || rise_cnt_r == 2'h3) else $error("sync width wrong");
   a_oe_release: assert property ($fell(PCM_DOUT_OE_OUT) && PCM_CLK_OE_OUT |-> !PCM_CLK_OUT)
      else $error("data released outside falling edge");
   a_oe_start: assert property ($rose(PCM_DOUT_OE_OUT) && PCM_CLK_OE_OUT |-> $rose(PCM_CLK_OUT))
      else $error("data drive not at a clock rise");
   a_dout_edge: assert property (PCM_CLK_OE_OUT && $past(PCM_DOUT_OE_OUT) && PCM_DOUT_OE_OUT
      && $changed(PCM_DOUT_OUT) |-> $rose(PCM_CLK_OUT)) else $error("data changed mid bit");
endmodule // psa_port_checker

bind psa_port psa_port_checker psa_port_checker_inst (.SYS_CLK_IN(SYS_CLK_IN),
   .RSTN_IN(RSTN_IN), .WB_ACK_OUT(WB_ACK_OUT), .PCM_CLK_OUT(PCM_CLK_OUT),
   .PCM_CLK_OE_OUT(PCM_CLK_OE_OUT), .PCM_SYNC_OUT(PCM_SYNC_OUT),
   .PCM_SYNC_OE_OUT(PCM_SYNC_OE_OUT), .PCM_DOUT_OUT(PCM_DOUT_OUT),
   .PCM_DOUT_OE_OUT(PCM_DOUT_OE_OUT));

// >>> tb/psa_codec_model.sv
`timescale 1ns/1ps
// far-side pcm master: bit clock, short or long sync and receive data
module psa_codec_model #(parameter int FRAME = 64) (
   input wire logic en_in,
   input wire logic long_in,
   input wire logic [3:0] slot_in,
   input wire logic [15:0] word_in,
   output logic clk_out,
   output logic sync_out,
   output logic din_out
);
   logic ph;
   logic run;
   int bc;
   int nb;
   // free-running phase; the pin only moves while enabled
   initial begin
      ph = 1'b0;
      run = 1'b0;
      bc = 0;
      sync_out = 1'b0;
      din_out = 1'b0;
      forever #80 ph = ~ph;
   end
   // enable taken while the phase is low, so no clipped pulse reaches the pin
   always @(negedge ph) run <= en_in;
   assign clk_out = run & ph;
   // each rise launches a bit; idle data toggles so it never looks held
   always @(posedge ph) begin
      nb = run ? bc : FRAME;
      bc = (nb >= FRAME - 1) ? 0 : nb + 1;
      sync_out <= run && (long_in ? nb < psa_pkg::LONG_SYNC_BITS : nb == FRAME - 1);
      din_out <= (run && nb / 16 == slot_in) ? word_in[15 - nb % 16] : ~din_out;
   end
endmodule // psa_codec_model

// >>> tb/psa_port_tb.sv
`timescale 1ns/1ps
module psa_port_tb;
   logic clk, rstn, cyc, stb, we, ack, m_en, m_long, c_p, d_p, oe_p;
   logic pclk_o, pclk_oe, fs_o, fs_oe, dout, dout_oe, m_clk, m_fs, m_din;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, rd;
   logic [15:0] sr, word;
   logic [3:0] bc;
   logic [12:0] smp;
   int wc, err_total, n_tests;
   localparam logic [7:0] FMTS [4] = '{8'h61, 8'h02, 8'h97, 8'h20};
   // shared clock and sync lines
   wire bclk = pclk_oe ? pclk_o : m_clk;
   wire fs = fs_oe ? fs_o : m_fs;

   psa_port psa_port_inst (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PCM_CLK_IN(bclk), .PCM_CLK_OUT(pclk_o),
      .PCM_CLK_OE_OUT(pclk_oe), .PCM_SYNC_IN(fs), .PCM_SYNC_OUT(fs_o),
      .PCM_SYNC_OE_OUT(fs_oe), .PCM_DIN_IN(m_din), .PCM_DOUT_OUT(dout),
      .PCM_DOUT_OE_OUT(dout_oe));
   psa_codec_model #(.FRAME(64)) psa_codec_model_inst (.en_in(m_en), .long_in(m_long),
      .slot_in(4'h1),
      .word_in({13'h1234, 3'h5}), .clk_out(m_clk), .sync_out(m_fs), .din_out(m_din));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // shifts owned bits in at each falling bit clock, one word per slot
   always @(posedge clk) begin
      c_p <= bclk;
      d_p <= dout;
      oe_p <= dout_oe;
      if (!oe_p) bc <= 4'h0;
      else if (c_p && !bclk) begin
         sr <= {sr[14:0], d_p};
         bc <= bc + 4'h1;
         if (bc == 4'hF) begin
            word <= {sr[14:0], d_p};
            wc <= wc + 1;
         end
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t reg got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t word got %h exp %h", $time, g, e);
      end
   endtask
   // one classic bus cycle, held until ack is sampled
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      rd = rdat;
      if (n == 500) begin
         err_total++;
         $display("[ERR] %0t ack got %h exp %h", $time, 1'b0, 1'b1);
         tally_and_finish();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb_cycle(1'b0, a, 32'h0);
      chk_reg(rd, e);
   endtask
   task automatic wait_word();
      int n;
      int w0;
      w0 = wc;
      n = 0;
      while (wc == w0 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (wc == w0) begin
         err_total++;
         $display("[ERR] %0t words got %h exp %h", $time, wc, w0 + 1);
         tally_and_finish();
      end
   endtask
   // expected slot word as it appears on the line, first bit highest
   function automatic logic [15:0] exp_word(input logic [12:0] s, input logic [7:0] f);
      logic [15:0] fl;
      logic [15:0] w;
      logic [15:0] r;
      case (f[1:0])
         2'h0: fl = 16'h0000;
         2'h1: fl = 16'hFFFF;
         2'h2: fl = {16{s[12]}};
         default: fl = {f[4:2], 10'h000, f[4:2]};
      endcase
      w = ({3'h0, s} << f[6:5]) | (fl & ~(16'h1FFF << f[6:5]));
      for (int i = 0; i < 16; i++) r[i] = w[15 - i];
      return f[7] ? r : w;
   endfunction

   initial begin
      {rstn, cyc, stb, we, m_en, m_long, c_p, d_p, oe_p} = 9'h000;
      {adr, wdat, sr, word, bc} = 76'h0;
      {wc, err_total, n_tests} = 96'h0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      // reset values, read-only status, unmapped place
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h08, 32'h60);
      wb_cycle(1'b1, 8'h10, 32'hFF);
      rd_chk(8'h10, 32'h80);
      wb_cycle(1'b1, 8'h24, 32'hFFFFFFFF);
      rd_chk(8'h24, 32'h0);
      // master, long sync, 1024 kHz at 16 kHz, channel 0 in slot 3; queue filled
      wb_cycle(1'b1, 8'h04, 32'h13);
      wb_cycle(1'b1, 8'h00, 32'h3F);
      for (int i = 0; i < 5; i++) wb_cycle(1'b1, 8'h0C, 32'h1000 + i);
      repeat (4) @(posedge clk);
      rd_chk(8'h10, 32'h48);
      // queue drains in order, one word per frame
      for (int i = 0; i < 5; i++) begin
         smp = 13'h1000 + 13'(i);
         wait_word();
         chk_word(word, {smp, 3'h0});
      end
      rd_chk(8'h10, 32'h81);
      // master with short sync for the format checks
      wb_cycle(1'b1, 8'h00, 32'h3B);
      // fill modes, placement and bit order
      smp = 13'h1A5C;
      for (int i = 0; i < 4; i++) begin
         wb_cycle(1'b1, 8'h08, {24'h0, FMTS[i]});
         wb_cycle(1'b1, 8'h0C, {19'h0, smp});
         wait_word();
         chk_word(word, exp_word(smp, FMTS[i]));
      end
      // slave, short sync, 512 kHz at 8 kHz, channel 1 in slot 1
      wb_cycle(1'b1, 8'h00, 32'h0);
      wb_cycle(1'b1, 8'h08, 32'h60);
      wb_cycle(1'b1, 8'h04, 32'h220);
      wb_cycle(1'b1, 8'h00, 32'h21);
      m_en <= 1'b1;
      wait_word();
      repeat (8) @(posedge clk); // let the slot end retire the holder first
      wb_cycle(1'b1, 8'h0C, 32'h10ABC);
      wait_word();
      chk_word(word, 16'h55E0);
      repeat (40) @(posedge clk);
      rd_chk(8'h18, 32'h1234);
      rd_chk(8'h10, 32'h81);
      // slave, long sync: the sync rise seen at a fall re-anchors bit zero
      wb_cycle(1'b1, 8'h00, 32'h25);
      m_long <= 1'b1;
      wait_word();
      repeat (8) @(posedge clk);
      wb_cycle(1'b1, 8'h0C, 32'h10123);
      wait_word();
      chk_word(word, 16'h0918);
      repeat (40) @(posedge clk);
      rd_chk(8'h18, 32'h1234);
      tally_and_finish();
   end
endmodule // psa_port_tb
